// ==== verilog/timing_pin_routing_dio.sv ====
// Operation
// - Eight digital lines, each own direction
// - Timing enters via function pins or bus
// - Pin output source is fixed per pin
// - Any present pin selectable as timing source; absent pins 2 and 5 read low
// - Per-pin output driver enable
// - Per-route polarity; edge or level on routes 4-7, edge only on 0-3
// - Polarity always; edge/level choice on routes 4-7 only
// - Long level still one edge
// - Level mode adds no width limits
// - Without connector, only shared bus usable
// - Trigger outputs are 50-100 ns pulses
// - Pin drivers off after reset
//
// The address map and the APB interface to the registers are this design's own decisions.
`timescale 1ns/10ps
module timing_pin_routing_dio (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        connector_strap,
  input  wire logic [9:0]  timing_src,
  input  wire logic [6:0]  timing_bus_src,
  output logic      [7:0]  timing_dest,
  input  wire logic [9:0]  programmable_function_pin_in,
  output logic      [9:0]  programmable_function_pin_out,
  output logic      [9:0]  programmable_function_pin_oe_n,
  input  wire logic [6:0]  shared_timing_bus_in,
  output logic      [6:0]  shared_timing_bus_out,
  output logic      [6:0]  shared_timing_bus_oe_n,
  input  wire logic [7:0]  digital_line_port_in,
  output logic      [7:0]  digital_line_port_out,
  output logic      [7:0]  digital_line_port_oe_n
);

  timing_pin_pkg::apb_state_type apb_state_r;

  logic [7:0]  dir_r;
  logic [7:0]  dout_r;
  logic [9:0]  pin_oe_r;
  logic [6:0]  bus_oe_r;
  logic [4:0]  route_sel_r   [8];
  logic [7:0]  route_pol_r;
  logic [7:0]  route_level_r;
  logic        present_r;
  logic [1:0]  settle_r;
  logic [25:0] sync_bits;
  logic [9:0]  pin_sync_lvl;
  logic [6:0]  bus_sync_lvl;
  logic [7:0]  dio_sync_lvl;
  logic        strap_sync;
  logic [7:0]  src_lvl;
  logic [7:0]  src_lvl_d_r;
  logic [9:0]  src_d_r;
  logic [9:0]  stretched;
  logic [31:0] rdata_nxt;
  logic        addr_ok;
  logic        access;
  logic        wr_en;
  logic        route_hit;
  logic [2:0]  route_idx;
  logic [11:0] route_off;

  // All outside levels pass two flops first
  pin_sync #(
    .WIDTH (timing_pin_pkg::SYNC_WIDTH)
  ) u_sync (
    .pclk     (pclk),
    .presetn  (presetn),
    .async_in ({connector_strap,
                digital_line_port_in,
                shared_timing_bus_in,
                programmable_function_pin_in}),
    .sync_out (sync_bits)
  );

  assign pin_sync_lvl = sync_bits[9:0];
  assign bus_sync_lvl = sync_bits[16:10];
  assign dio_sync_lvl = sync_bits[24:17];
  assign strap_sync   = sync_bits[25];

  // Connector strap caught once the synchroniser has settled
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      settle_r <= 2'h0;
    else if (settle_r != timing_pin_pkg::SETTLE_CYCLES)
      settle_r <= settle_r + 2'h1;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      present_r <= 1'b0;
    else if (settle_r == timing_pin_pkg::SETTLE_CYCLES - 2'h1)
      present_r <= strap_sync;
  end

  // APB decode
  assign access    = psel & penable &
                     (apb_state_r == timing_pin_pkg::APB_ANSWER);
  assign wr_en     = access & pwrite & addr_ok;
  assign route_off = paddr - timing_pin_pkg::ROUTE_BASE;
  assign route_idx = route_off[4:2];
  assign route_hit = (paddr >= timing_pin_pkg::ROUTE_BASE) &&
                     (route_off < 12'(timing_pin_pkg::ROUTE_COUNT * 4)) &&
                     (paddr[1:0] == 2'h0);

  always_comb
  begin
    addr_ok   = 1'b1;
    rdata_nxt = 32'h0000_0000;
    if (route_hit)
    begin
      rdata_nxt[timing_pin_pkg::ROUTE_SEL_LSB +: 5] = route_sel_r[route_idx];
      rdata_nxt[timing_pin_pkg::ROUTE_POL_BIT]      = route_pol_r[route_idx];
      rdata_nxt[timing_pin_pkg::ROUTE_LEVEL_BIT]    = route_level_r[route_idx];
    end
    else
    begin
      unique case (paddr)
        timing_pin_pkg::DIR_OFFSET:    rdata_nxt[7:0] = dir_r;
        timing_pin_pkg::DOUT_OFFSET:   rdata_nxt[7:0] = dout_r;
        timing_pin_pkg::DIN_OFFSET:    rdata_nxt[7:0] = dio_sync_lvl;
        timing_pin_pkg::PIN_OE_OFFSET: rdata_nxt[9:0] = pin_oe_r;
        timing_pin_pkg::PIN_IN_OFFSET: rdata_nxt[9:0] = pin_sync_lvl;
        timing_pin_pkg::BUS_OE_OFFSET: rdata_nxt[6:0] = bus_oe_r;
        timing_pin_pkg::STATUS_OFFSET: rdata_nxt[0]   = present_r;
        default:                       addr_ok        = 1'b0;
      endcase
    end
  end

  // Zero-wait answer: pready in the first access cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      apb_state_r <= timing_pin_pkg::APB_IDLE;
    else if (psel && !penable && apb_state_r == timing_pin_pkg::APB_IDLE)
      apb_state_r <= timing_pin_pkg::APB_ANSWER;
    else
      apb_state_r <= timing_pin_pkg::APB_IDLE;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end
    else if (psel && !penable && apb_state_r == timing_pin_pkg::APB_IDLE)
    begin
      pready  <= 1'b1;
      pslverr <= ~addr_ok;
      prdata  <= pwrite ? 32'h0000_0000 : rdata_nxt;
    end
    else
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end
  end

  // Digital line direction and output registers
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      dir_r <= timing_pin_pkg::DIR_RESET;
    else if (wr_en && paddr == timing_pin_pkg::DIR_OFFSET)
      dir_r <= pwdata[7:0];
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      dout_r <= timing_pin_pkg::DOUT_RESET;
    else if (wr_en && paddr == timing_pin_pkg::DOUT_OFFSET)
      dout_r <= pwdata[7:0];
  end

  // Pin and bus driver enables
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pin_oe_r <= timing_pin_pkg::PIN_OE_RESET;
    else if (wr_en && paddr == timing_pin_pkg::PIN_OE_OFFSET)
      pin_oe_r <= pwdata[9:0] & timing_pin_pkg::PIN_CAN_DRIVE &
                  timing_pin_pkg::PIN_PRESENT;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      bus_oe_r <= timing_pin_pkg::BUS_OE_RESET;
    else if (wr_en && paddr == timing_pin_pkg::BUS_OE_OFFSET)
      bus_oe_r <= pwdata[6:0];
  end

  // Digital line port drive
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      digital_line_port_out  <= 8'h00;
      digital_line_port_oe_n <= 8'hff;
    end
    else
    begin
      digital_line_port_out  <= dout_r & {8{present_r}};
      digital_line_port_oe_n <= ~(dir_r & {8{present_r}});
    end
  end

  // Shared timing bus drive
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      shared_timing_bus_out  <= 7'h00;
      shared_timing_bus_oe_n <= 7'h7f;
    end
    else
    begin
      shared_timing_bus_out  <= timing_bus_src;
      shared_timing_bus_oe_n <= ~bus_oe_r;
    end
  end

  // Per-pin fixed output source
  genvar p;
  generate
    for (p = 0; p < timing_pin_pkg::PIN_COUNT; p++)
    begin : g_pin
      always_ff @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
          src_d_r[p] <= 1'b0;
        else
          src_d_r[p] <= timing_src[p];
      end

      if (timing_pin_pkg::PIN_TRIGGER[p])
      begin : g_trig
        pulse_stretch u_stretch (
          .pclk    (pclk),
          .presetn (presetn),
          .trigger (timing_src[p] & ~src_d_r[p]),
          .pulse_r (stretched[p])
        );
      end
      else
      begin : g_level
        assign stretched[p] = src_d_r[p];
      end

      always_ff @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
        begin
          programmable_function_pin_out[p]  <= 1'b0;
          programmable_function_pin_oe_n[p] <= 1'b1;
        end
        else
        begin
          programmable_function_pin_out[p]  <= stretched[p];
          programmable_function_pin_oe_n[p] <=
            ~(pin_oe_r[p] & present_r);
        end
      end
    end
  endgenerate

  // Per-route source selection and detection
  genvar r;
  generate
    for (r = 0; r < timing_pin_pkg::ROUTE_COUNT; r++)
    begin : g_route
      logic [4:0] bus_idx;
      logic       raw_lvl;

      assign bus_idx = route_sel_r[r] - timing_pin_pkg::SEL_BUS_BASE;

      always_comb
      begin
        raw_lvl = 1'b0;
        if (route_sel_r[r] < timing_pin_pkg::SEL_BUS_BASE)
          raw_lvl = pin_sync_lvl[route_sel_r[r][3:0]] &
                    timing_pin_pkg::PIN_PRESENT[route_sel_r[r][3:0]] &
                    present_r;
        else if (bus_idx < 5'(timing_pin_pkg::BUS_WIDTH))
          raw_lvl = bus_sync_lvl[bus_idx[2:0]];
      end

      assign src_lvl[r] = raw_lvl ^ route_pol_r[r];

      always_ff @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
        begin
          route_sel_r[r]   <= timing_pin_pkg::SEL_RESET;
          route_pol_r[r]   <= 1'b0;
          route_level_r[r] <= 1'b0;
        end
        else if (wr_en && route_hit && route_idx == 3'(r))
        begin
          route_sel_r[r]   <=
            pwdata[timing_pin_pkg::ROUTE_SEL_LSB +: 5];
          route_pol_r[r]   <= pwdata[timing_pin_pkg::ROUTE_POL_BIT];
          route_level_r[r] <= pwdata[timing_pin_pkg::ROUTE_LEVEL_BIT] &
                              timing_pin_pkg::ROUTE_LEVEL_OK[r];
        end
      end

      always_ff @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
          src_lvl_d_r[r] <= 1'b0;
        else
          src_lvl_d_r[r] <= src_lvl[r];
      end

      always_ff @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
          timing_dest[r] <= 1'b0;
        else if (route_level_r[r])
          timing_dest[r] <= src_lvl[r];
        else
          timing_dest[r] <= src_lvl[r] & ~src_lvl_d_r[r];
      end
    end
  endgenerate

endmodule

// ==== verilog/timing_pin_pkg.sv ====
package timing_pin_pkg;

  // Sizes of the pin groups
  localparam int PIN_COUNT   = 10;
  localparam int DIO_WIDTH   = 8;
  localparam int BUS_WIDTH   = 7;
  localparam int ROUTE_COUNT = 8;
  localparam int SEL_WIDTH   = 5;
  localparam int SYNC_WIDTH  = PIN_COUNT + BUS_WIDTH + DIO_WIDTH + 1;

  // Pins 2 and 5 do not exist; pin 7 has no output driver
  localparam logic [PIN_COUNT-1:0] PIN_PRESENT   = 10'h3db;
  localparam logic [PIN_COUNT-1:0] PIN_CAN_DRIVE = 10'h35b;
  // Pins whose fixed source is a trigger pulse
  localparam logic [PIN_COUNT-1:0] PIN_TRIGGER   = 10'h043;
  // Routed timing signals that accept level detection
  localparam logic [ROUTE_COUNT-1:0] ROUTE_LEVEL_OK = 8'hf0;

  // Register byte offsets
  localparam logic [11:0] DIR_OFFSET     = 12'h000;
  localparam logic [11:0] DOUT_OFFSET    = 12'h004;
  localparam logic [11:0] DIN_OFFSET     = 12'h008;
  localparam logic [11:0] PIN_OE_OFFSET  = 12'h00c;
  localparam logic [11:0] PIN_IN_OFFSET  = 12'h010;
  localparam logic [11:0] BUS_OE_OFFSET  = 12'h014;
  localparam logic [11:0] STATUS_OFFSET  = 12'h018;
  localparam logic [11:0] ROUTE_BASE     = 12'h020;
  localparam logic [11:0] ROUTE_STEP     = 12'h004;

  // Route register fields
  localparam int ROUTE_SEL_LSB   = 0;
  localparam int ROUTE_POL_BIT   = 8;
  localparam int ROUTE_LEVEL_BIT = 9;
  // Selector codes from this value up to this value plus 6 pick a shared bus line
  localparam logic [SEL_WIDTH-1:0] SEL_BUS_BASE = 5'h0a;

  // Reset values
  localparam logic [DIO_WIDTH-1:0]   DIR_RESET    = 8'h00;
  localparam logic [DIO_WIDTH-1:0]   DOUT_RESET   = 8'h00;
  localparam logic [PIN_COUNT-1:0]   PIN_OE_RESET = 10'h000;
  localparam logic [BUS_WIDTH-1:0]   BUS_OE_RESET = 7'h00;
  localparam logic [SEL_WIDTH-1:0]   SEL_RESET    = 5'h00;

  // Timing
  localparam int CLK_PERIOD_NS    = 40;
  localparam int IN_PULSE_MIN_NS  = 10;
  localparam int PULSE_MIN_NS     = 50;
  localparam int PULSE_MAX_NS     = 100;
  localparam int PULSE_MIN_CYCLES =
    (PULSE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PULSE_MAX_CYCLES = PULSE_MAX_NS / CLK_PERIOD_NS;
  localparam logic [1:0] PULSE_CYCLES = 2'(PULSE_MIN_CYCLES);
  localparam logic [1:0] SETTLE_CYCLES = 2'h3;

  typedef enum logic [0:0] {
    APB_IDLE   = 1'b0,
    APB_ANSWER = 1'b1
  } apb_state_type;

endpackage

// ==== verilog/pin_sync.sv ====
`timescale 1ns/10ps
module pin_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] stage1_r;

  // Two flops per bit
  genvar i;
  generate
    for (i = 0; i < WIDTH; i++)
    begin : g_bit
      always_ff @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
        begin
          stage1_r[i] <= 1'b0;
          sync_out[i] <= 1'b0;
        end
        else
        begin
          stage1_r[i] <= async_in[i];
          sync_out[i] <= stage1_r[i];
        end
      end
    end
  endgenerate

endmodule

// ==== verilog/pulse_stretch.sv ====
`timescale 1ns/10ps
module pulse_stretch (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic trigger,
  output logic      pulse_r
);

  logic [1:0] count_r;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      count_r <= 2'h0;
    else if (trigger)
      count_r <= timing_pin_pkg::PULSE_CYCLES;
    else if (count_r != 2'h0)
      count_r <= count_r - 2'h1;
  end

  // High for a fixed number of cycles per trigger
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pulse_r <= 1'b0;
    else
      pulse_r <= trigger | (count_r > 2'h1);
  end

endmodule

// ==== test/timing_pin_routing_dio_asserts.sv ====
`timescale 1ns/10ps
module pin_route_checker (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  input wire logic        connector_strap,
  input wire logic [9:0]  timing_src,
  input wire logic [7:0]  timing_dest,
  input wire logic [9:0]  programmable_function_pin_out,
  input wire logic [9:0]  programmable_function_pin_oe_n,
  input wire logic [7:0]  digital_line_port_out,
  input wire logic [7:0]  digital_line_port_oe_n
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  logic wr;
  assign wr = psel && penable && pwrite && pready;

  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_answer;
    pready ##1 !pready;
  endsequence
  sequence s_trig;
    $rose(programmable_function_pin_out[0]) ##0
      programmable_function_pin_out[0] [*2] ##1
      !programmable_function_pin_out[0];
  endsequence

  a_apb_one_pulse: assert property (s_setup |=> s_answer)
    else $error("pready is not one pulse after setup");
  a_drivers_off_start: assert property ($rose(presetn) |->
    (&programmable_function_pin_oe_n && &digital_line_port_oe_n) [*3])
    else $error("drivers enabled right after reset");
  a_pin_oe_write: assert property (
    wr && paddr == 12'h00c && connector_strap |-> ##2
    programmable_function_pin_oe_n ==
    ~($past(pwdata[9:0], 2) & timing_pin_pkg::PIN_CAN_DRIVE))
    else $error("pin driver enables wrong after write");
  a_dir_write: assert property (
    wr && paddr == 12'h000 && connector_strap |-> ##2
    digital_line_port_oe_n == ~$past(pwdata[7:0], 2))
    else $error("line directions wrong after write");
  a_dout_write: assert property (
    wr && paddr == 12'h004 && connector_strap |-> ##2
    digital_line_port_out == $past(pwdata[7:0], 2))
    else $error("line outputs wrong after write");
  a_no_connector: assert property (!connector_strap |->
    &programmable_function_pin_oe_n && &digital_line_port_oe_n)
    else $error("front drivers on without connector");
  a_trigger_width: assert property (
    $rose(timing_src[0]) && connector_strap |-> ##[1:3] s_trig)
    else $error("trigger output pulse width wrong or missing");
  a_edge_single: assert property (
    (timing_dest[3:0] & $past(timing_dest[3:0])) == 4'h0)
    else $error("edge event longer than one cycle");
endmodule

bind timing_pin_routing_dio pin_route_checker i_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
  .connector_strap(connector_strap), .timing_src(timing_src),
  .timing_dest(timing_dest),
  .programmable_function_pin_out(programmable_function_pin_out),
  .programmable_function_pin_oe_n(programmable_function_pin_oe_n),
  .digital_line_port_out(digital_line_port_out),
  .digital_line_port_oe_n(digital_line_port_oe_n)
);

// ==== test/ext_party.sv ====
`timescale 1ns/10ps
module ext_party #(
  parameter int W = 8
) (
  input  wire logic [W-1:0] dev_out,
  input  wire logic [W-1:0] dev_oe_n,
  input  wire logic [W-1:0] ext_val,
  input  wire logic [W-1:0] ext_en,
  output logic      [W-1:0] lvl
);
  // Drives only released lines; undriven lines sit at the pull-up
  assign lvl = (~dev_oe_n & dev_out)
             | (dev_oe_n & ~ext_en)
             | (dev_oe_n & ext_en & ext_val);
endmodule

// ==== test/tb.sv ====
`timescale 1ns/10ps
module tb;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic        strap = 1'b1;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [9:0]  tsrc = 10'h000;
  logic [6:0]  tbsrc = 7'h00;
  logic [7:0]  tdest;
  logic [9:0]  p_out, p_oen, p_lvl;
  logic [9:0]  p_val = 10'h000;
  logic [9:0]  p_en = 10'h000;
  logic [6:0]  b_out, b_oen, b_lvl;
  logic [6:0]  b_val = 7'h00;
  logic [7:0]  d_out, d_oen, d_lvl;
  logic [7:0]  d_val = 8'h00;
  logic [7:0]  d_en = 8'h00;
  int          miscompares = 0;
  int          cmp_count = 0;

  timing_pin_routing_dio i_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .connector_strap(strap),
    .timing_src(tsrc), .timing_bus_src(tbsrc), .timing_dest(tdest),
    .programmable_function_pin_in(p_lvl),
    .programmable_function_pin_out(p_out),
    .programmable_function_pin_oe_n(p_oen),
    .shared_timing_bus_in(b_lvl), .shared_timing_bus_out(b_out),
    .shared_timing_bus_oe_n(b_oen), .digital_line_port_in(d_lvl),
    .digital_line_port_out(d_out), .digital_line_port_oe_n(d_oen)
  );
  ext_party #(.W(10)) i_pins (.dev_out(p_out), .dev_oe_n(p_oen),
    .ext_val(p_val), .ext_en(p_en), .lvl(p_lvl));
  ext_party #(.W(7)) i_bus (.dev_out(b_out), .dev_oe_n(b_oen),
    .ext_val(b_val), .ext_en(7'h7f), .lvl(b_lvl));
  ext_party #(.W(8)) i_dio (.dev_out(d_out), .dev_oe_n(d_oen),
    .ext_val(d_val), .ext_en(d_en), .lvl(d_lvl));

  always #20 pclk = ~pclk;

  task automatic cmp(input logic [31:0] g, input logic [31:0] x);
    cmp_count++;
    if (g !== x)
    begin
      miscompares++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, x);
    end
  endtask

  task automatic apb(input logic [11:0] a, input logic w,
                     input logic [31:0] d, output logic [31:0] r,
                     output logic e);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    if (n >= 20)
      miscompares++;
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    apb(a, 1'b1, d, r, e);
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] x,
                    input logic xe);
    logic [31:0] r;
    logic        e;
    apb(a, 1'b0, 32'h0, r, e);
    cmp(r, x);
    cmp({31'h0, e}, {31'h0, xe});
  endtask

  task automatic do_reset(input logic s);
    @(posedge pclk);
    presetn <= 1'b0;
    strap <= s;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    repeat (4) @(posedge pclk);
  endtask

  task automatic t_reset();
    cmp({22'h0, p_oen}, 32'h3ff);
    cmp({24'h0, d_oen}, 32'hff);
    rd(12'h000, 32'h0, 1'b0);
    rd(12'h00c, 32'h0, 1'b0);
    rd(12'h018, 32'h1, 1'b0);
    rd(12'h01c, 32'h0, 1'b1);
    $display("test reset done");
  endtask

  task automatic t_dio();
    logic [7:0] dir;
    for (int i = 0; i < 2; i++)
    begin
      dir = i ? 8'hf0 : 8'h0f;
      d_val <= 8'hc3;
      d_en <= 8'hff;
      wr(12'h000, {24'h0, dir});
      wr(12'h004, 32'ha5);
      repeat (4) @(posedge pclk);
      cmp({24'h0, d_oen}, {24'h0, ~dir});
      cmp({24'h0, d_out}, 32'ha5);
      rd(12'h008, {24'h0, (8'ha5 & dir) | (8'hc3 & ~dir)}, 1'b0);
      rd(12'h004, 32'ha5, 1'b0);
    end
    $display("test digital lines done");
  endtask

  task automatic t_pins();
    wr(12'h00c, 32'h3ff);
    repeat (2) @(posedge pclk);
    cmp({22'h0, p_oen}, {22'h0, ~timing_pin_pkg::PIN_CAN_DRIVE});
    rd(12'h00c, {22'h0, timing_pin_pkg::PIN_CAN_DRIVE}, 1'b0);
    cmp({22'h0, p_lvl & 10'h008}, 32'h0);
    tsrc <= 10'h008;
    repeat (4) @(posedge pclk);
    cmp({22'h0, p_lvl & 10'h008}, 32'h8);
    rd(12'h010, {22'h0, ~timing_pin_pkg::PIN_CAN_DRIVE | 10'h008},
       1'b0);
    tsrc <= 10'h000;
    wr(12'h00c, 32'h0);
    $display("test pin drivers done");
  endtask

  task automatic t_trig();
    int pins[3] = '{0, 1, 6};
    int n;
    foreach (pins[i])
    begin
      n = 0;
      tsrc[pins[i]] <= 1'b1;
      @(posedge pclk);
      tsrc[pins[i]] <= 1'b0;
      repeat (8)
      begin
        @(posedge pclk);
        n += p_out[pins[i]];
      end
      cmp(n, 32'h2);
    end
    $display("test trigger outputs done");
  endtask

  task automatic t_route();
    logic [4:0] sel;
    logic       inv;
    logic       lvl;
    int         n;
    p_en <= 10'h100;
    for (int k = 0; k < 8; k++)
    begin
      inv = k[1];
      lvl = k >= 4;
      sel = k[0] ? 5'h0a + 5'(k >> 1) : 5'h08;
      wr(12'h020 + 12'(4 * k), {22'h0, 1'b1, inv, 3'h0, sel});
      rd(12'h020 + 12'(4 * k), {22'h0, lvl, inv, 3'h0, sel}, 1'b0);
      repeat (4) @(posedge pclk);
      for (int ph = 1; ph >= 0; ph--)
      begin
        p_val <= ph ? 10'h100 : 10'h000;
        b_val <= ph ? 7'h7f : 7'h00;
        n = 0;
        repeat (8)
        begin
          @(posedge pclk);
          n += tdest[k];
        end
        if (lvl)
          cmp({31'h0, tdest[k]}, {31'h0, ph[0] ^ inv});
        else
          cmp(n, {31'h0, ph[0] ^ inv});
      end
    end
    $display("test routing done");
  endtask

  task automatic t_noconn();
    do_reset(1'b0);
    wr(12'h00c, 32'h3ff);
    wr(12'h000, 32'hff);
    wr(12'h014, 32'h7f);
    tbsrc <= 7'h55;
    repeat (4) @(posedge pclk);
    cmp({22'h0, p_oen}, 32'h3ff);
    cmp({24'h0, d_oen}, 32'hff);
    cmp({25'h0, b_oen}, 32'h0);
    cmp({25'h0, b_lvl}, 32'h55);
    rd(12'h018, 32'h0, 1'b0);
    rd(12'h014, 32'h7f, 1'b0);
    do_reset(1'b1);
    $display("test no connector done");
  endtask

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  initial
  begin
    #(40 * 6000);
    miscompares++;
    tally_and_finish();
  end

  initial
  begin
    do_reset(1'b1);
    t_reset();
    t_dio();
    t_pins();
    t_trig();
    t_route();
    t_noconn();
    tally_and_finish();
  end
endmodule
